// *** rtl/relc_relay_ctrl.sv ***
/*
  Relay output controller: buzzer plus four relays, door events, PIN
  checks, schedules, overrides and control cards, Wishbone register file.
  Assumes reader, clock and card logic on clk_i; door and input pins async.
*/
// Notes on behaviour
// - Four relays plus buzzer, buzzer handled exactly like a relay.
// - Unit mode loads default source per output.
// - Forced-on override keeps output energised until override changes.
// - Forced-off override keeps output off until override changes.
// - Programmed override: output follows its event source and schedule.
// - Programmed-then-on: on now, back to programmed at next off.
// - Programmed-then-off: off now, back to programmed at next on.
// - Pulse override and instant events energise for hold time, less up to one tick.
// - Door sources from this unit; inputs and faults selectable; sharing.
// - Lock strike energises for strike time on accepted credential.
// - Shunt with strike; ends at strike end or at door close.
// - Shunt also drops when local ajar timer expires.
// - Ajar-assigned output energises on local or remote ajar.
// - Door opening without strike raises door forced event.
// - PIN one above stored raises duress and pulses output.
// - Unknown card or PIN raises bad ID and pulses output.
// - Fourth wrong PIN raises bad PIN and pulses output.
// - Input-follow output is on while the chosen input is on.
// - Any input fault raises the input fault source.
// - Schedule entry: time, weekdays, on/off/pulse, applied on match.
// - Holiday qualifier gates schedule entries only.
// - Control card toggles forced-on and programmed; PIN needs PIN-only.
`timescale 1ns/1ns
`default_nettype none
module relc_relay_ctrl #(
  parameter int unsigned TICK_CYCLES = relc_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] door_open_i,
  input wire logic [7:0] in_pin_i,
  input wire logic [7:0] in_fault_i,
  input wire relc_pkg::relc_rdr_ev_type [1:0] rdr_ev_i,
  input wire relc_pkg::relc_time_type time_i,
  input wire logic [4:0] ctrl_card_i,
  input wire logic ctrl_card_pin_i,
  output logic buzzer_o,
  output logic [3:0] relay_o
);

  function automatic logic [7:0] relay_adr(input int unsigned n,
                                           input logic [7:0] ofs);
    relay_adr = 8'(relc_pkg::ADR_RELAY_BASE +
                   8'(n) * relc_pkg::ADR_RELAY_STRIDE + ofs);
  endfunction : relay_adr

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
  endfunction : merge

  // Default source per output for a unit mode
  function automatic relc_pkg::relc_cfg_type dflt(
      input relc_pkg::relc_mode_type m, input int unsigned n,
      input relc_pkg::relc_cfg_type old);
    dflt = old;
    dflt.in_sel = 3'(n);
    dflt.door = 1'b0;
    dflt.src = relc_pkg::SRC_NONE;
    if (m == relc_pkg::MODE_LIFT) begin
      if (n != 0) begin
        dflt.src = relc_pkg::SRC_INPUT;
      end
    end else if (n == 0) begin
      dflt.src = relc_pkg::SRC_AJAR_L;
    end else if (n == 1) begin
      dflt.src = relc_pkg::SRC_STRIKE;
    end else if (n == 3) begin
      dflt.src = relc_pkg::SRC_SHUNT;
    end else if (m == relc_pkg::MODE_2R2D) begin
      dflt.door = 1'b1;
      dflt.src = (n == 2) ? relc_pkg::SRC_STRIKE : relc_pkg::SRC_SHUNT;
    end
  endfunction : dflt

  localparam int unsigned NO = relc_pkg::N_OUT;
  localparam int unsigned ND = relc_pkg::N_DOOR;

  // Bus slave
  logic ack_q;
  logic acc;
  logic wr;
  logic [31:0] rdata;
  logic [21:0] div_cnt;
  logic tick;
  relc_pkg::relc_mode_type mode;
  logic pin_only_en;
  logic [15:0] strike_time;
  logic [15:0] ajar_time;
  relc_pkg::relc_cfg_type cfg [NO];
  logic [15:0] hold [NO];
  relc_pkg::relc_sched_type sched [NO];
  logic [NO-1:0] out_q;

  assign acc = wb_cyc_i & wb_stb_i;
  assign wr = acc & wb_we_i & ack_q;
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc & ~ack_q;
    end
  end

  // Input synchronisers
  logic [17:0] pin_s1;
  logic [17:0] pin_s2;
  logic [1:0] door_q;
  logic [1:0] door;
  logic [7:0] inp;
  logic [7:0] flt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 18'h0_0000;
      pin_s2 <= 18'h0_0000;
      door_q <= 2'h0;
    end else begin
      pin_s1 <= {in_fault_i, in_pin_i, door_open_i};
      pin_s2 <= pin_s1;
      door_q <= pin_s2[1:0];
    end
  end
  assign door = pin_s2[1:0];
  assign inp = pin_s2[9:2];
  assign flt = pin_s2[17:10];

  // 100 ms tick
  assign tick = (div_cnt == 22'(TICK_CYCLES - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div_cnt <= 22'h00_0000;
    end else begin
      div_cnt <= div_cnt + 22'h00_0001;
    end
  end

  // Door and reader events
  logic [15:0] strike_cnt [ND];
  logic [15:0] ajar_cnt [ND];
  logic [2:0] wrong_cnt [ND];
  logic [ND-1:0] strike_act;
  logic [ND-1:0] strike_q;
  logic [ND-1:0] shunt;
  logic [ND-1:0] opened;
  logic [ND-1:0] ajar_l;
  logic [ND-1:0] forced_ev;
  logic [ND-1:0] forced_lv;
  logic [ND-1:0] duress_ev;
  logic [ND-1:0] bad_pin_ev;
  logic [ND-1:0] dur_hit;
  logic [ND-1:0] pin_good;
  logic [ND-1:0] pin_bad;
  logic [ND-1:0] rls;
  logic [ND-1:0] ajar_hit;

  always_comb begin
    for (int d = 0; d < ND; d++) begin
      strike_act[d] = (strike_cnt[d] != 16'h0000);
      dur_hit[d] = rdr_ev_i[d].pin_check && (rdr_ev_i[d].pin_entered ==
                   rdr_ev_i[d].pin_stored + 16'h0001);
      pin_good[d] = rdr_ev_i[d].pin_check &&
                    (rdr_ev_i[d].pin_entered == rdr_ev_i[d].pin_stored);
      pin_bad[d] = rdr_ev_i[d].pin_check & ~dur_hit[d] & ~pin_good[d];
      rls[d] = rdr_ev_i[d].cred_ok | dur_hit[d];
      ajar_hit[d] = door[d] && ajar_time != 16'h0000 &&
                    ajar_cnt[d] == ajar_time;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int d = 0; d < ND; d++) begin
        strike_cnt[d] <= 16'h0000;
        ajar_cnt[d] <= 16'h0000;
        wrong_cnt[d] <= 3'h0;
      end
      strike_q <= '0;
      shunt <= '0;
      opened <= '0;
      ajar_l <= '0;
      forced_ev <= '0;
      forced_lv <= '0;
      duress_ev <= '0;
      bad_pin_ev <= '0;
    end else begin
      strike_q <= strike_act;
      for (int d = 0; d < ND; d++) begin
        if (rls[d]) begin
          strike_cnt[d] <= strike_time;
        end else if (tick && strike_act[d]) begin
          strike_cnt[d] <= strike_cnt[d] - 16'h0001;
        end
        if (!door[d]) begin
          ajar_cnt[d] <= 16'h0000;
        end else if (tick && ajar_cnt[d] != ajar_time) begin
          ajar_cnt[d] <= ajar_cnt[d] + 16'h0001;
        end
        ajar_l[d] <= ajar_hit[d];
        if (rls[d]) begin
          shunt[d] <= 1'b1;
        end else if ((ajar_hit[d] && !ajar_l[d]) ||
                     (!opened[d] && strike_q[d] && !strike_act[d]) ||
                     (opened[d] && door_q[d] && !door[d])) begin
          shunt[d] <= 1'b0;
        end
        if (rls[d] && !door[d]) begin
          opened[d] <= 1'b0;
        end else if (shunt[d] && door[d] && !door_q[d]) begin
          opened[d] <= 1'b1;
        end
        forced_ev[d] <= door[d] & ~door_q[d] & ~strike_act[d];
        if (forced_ev[d]) begin
          forced_lv[d] <= 1'b1;
        end else if (!door[d]) begin
          forced_lv[d] <= 1'b0;
        end
        duress_ev[d] <= dur_hit[d];
        bad_pin_ev[d] <= pin_bad[d] && wrong_cnt[d] == 3'h3;
        if (pin_good[d] || dur_hit[d]) begin
          wrong_cnt[d] <= 3'h0;
        end else if (pin_bad[d]) begin
          wrong_cnt[d] <= (wrong_cnt[d] == 3'h3) ? 3'h0 :
                          wrong_cnt[d] + 3'h1;
        end
      end
    end
  end

  // Per output programmed request
  logic [NO-1:0] src_lv;
  logic [NO-1:0] pulse_start;
  logic [NO-1:0] sched_on;
  logic [NO-1:0] sched_off;
  logic [NO-1:0] sched_lv;
  logic [NO-1:0] prog;
  logic [NO-1:0] prog_q;
  logic [NO-1:0] card_hit;
  logic [NO-1:0] cfg_wr;
  logic [15:0] pulse_cnt [NO];
  logic hol_ok [NO];

  always_comb begin
    for (int n = 0; n < NO; n++) begin
      automatic int unsigned d = int'(cfg[n].door);
      automatic logic hit = 1'b0;
      automatic logic ev = 1'b0;
      case (cfg[n].hol)
        relc_pkg::HOL_NOT: hol_ok[n] = ~time_i.holiday;
        relc_pkg::HOL_ONLY: hol_ok[n] = time_i.holiday;
        default: hol_ok[n] = 1'b1;
      endcase
      hit = sched[n].en && time_i.minute_pulse && hol_ok[n] &&
            sched[n].minute == time_i.minute && time_i.weekday != 3'h7 &&
            sched[n].days[time_i.weekday];
      sched_on[n] = hit && sched[n].act == relc_pkg::ACT_ON;
      sched_off[n] = hit && sched[n].act == relc_pkg::ACT_OFF;
      src_lv[n] = 1'b0;
      case (cfg[n].src)
        relc_pkg::SRC_STRIKE: src_lv[n] = strike_act[d];
        relc_pkg::SRC_SHUNT: src_lv[n] = shunt[d];
        relc_pkg::SRC_AJAR_L: src_lv[n] = ajar_l[d];
        relc_pkg::SRC_AJAR_R: src_lv[n] = rdr_ev_i[d].ajar_remote;
        relc_pkg::SRC_FORCED: src_lv[n] = forced_lv[d];
        relc_pkg::SRC_DURESS: ev = duress_ev[d];
        relc_pkg::SRC_BAD_ID: ev = rdr_ev_i[d].bad_id;
        relc_pkg::SRC_BAD_PIN: ev = bad_pin_ev[d];
        relc_pkg::SRC_INPUT: src_lv[n] = inp[cfg[n].in_sel];
        relc_pkg::SRC_IN_FAULT: src_lv[n] = |flt;
        default: src_lv[n] = 1'b0;
      endcase
      cfg_wr[n] = wr && wb_adr_i == relay_adr(n, relc_pkg::OFS_CFG);
      pulse_start[n] = ev || (hit && sched[n].act == relc_pkg::ACT_PULSE) ||
                       (cfg_wr[n] && wb_sel_i[0] &&
                        wb_dat_i[2:0] == relc_pkg::CTL_PULSE);
      card_hit[n] = ctrl_card_i[n] && (!ctrl_card_pin_i || pin_only_en);
      prog[n] = src_lv[n] | sched_lv[n] | (pulse_cnt[n] != 16'h0000);
    end
  end

  // Registers, overrides and outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= relc_pkg::MODE_2R2D;
      pin_only_en <= 1'b0;
      strike_time <= relc_pkg::STRIKE_RST;
      ajar_time <= relc_pkg::AJAR_RST;
      prog_q <= '0;
      sched_lv <= '0;
      out_q <= '0;
      for (int n = 0; n < NO; n++) begin
        cfg[n] <= dflt(relc_pkg::MODE_2R2D, n, '0);
        hold[n] <= relc_pkg::HOLD_RST;
        sched[n] <= '0;
        pulse_cnt[n] <= 16'h0000;
      end
    end else begin
      prog_q <= prog;
      if (wr && wb_adr_i == relc_pkg::ADR_UNIT && wb_sel_i[0]) begin
        mode <= relc_pkg::relc_mode_type'(wb_dat_i[relc_pkg::UNIT_MODE_LSB
                                                   +: 2]);
        pin_only_en <= wb_dat_i[relc_pkg::UNIT_PIN_ONLY_BIT];
      end
      if (wr && wb_adr_i == relc_pkg::ADR_STRIKE) begin
        strike_time <= 16'(merge({16'h0000, strike_time}, wb_dat_i,
                                 wb_sel_i));
      end
      if (wr && wb_adr_i == relc_pkg::ADR_AJAR) begin
        ajar_time <= 16'(merge({16'h0000, ajar_time}, wb_dat_i, wb_sel_i));
      end
      for (int n = 0; n < NO; n++) begin
        automatic relc_pkg::relc_cfg_type c;
        c = relc_pkg::relc_cfg_type'(merge(32'(cfg[n]), wb_dat_i,
                                           wb_sel_i));
        c.pad0 = 1'b0;
        c.pad1 = 2'h0;
        c.pad2 = 1'b0;
        c.pad3 = 15'h0000;
        if (wr && wb_adr_i == relc_pkg::ADR_UNIT && wb_sel_i[0]) begin
          cfg[n] <= dflt(relc_pkg::relc_mode_type'(wb_dat_i[1:0]), n,
                         cfg[n]);
        end else if (cfg_wr[n]) begin
          if (c.ctl == relc_pkg::CTL_PULSE) begin
            c.ctl = relc_pkg::CTL_PROG;
          end
          cfg[n] <= c;
        end else if (card_hit[n]) begin
          cfg[n].ctl <= (cfg[n].ctl == relc_pkg::CTL_ON) ?
                        relc_pkg::CTL_PROG : relc_pkg::CTL_ON;
        end else if (cfg[n].ctl == relc_pkg::CTL_PROG_ON &&
                     prog_q[n] && !prog[n]) begin
          cfg[n].ctl <= relc_pkg::CTL_PROG;
        end else if (cfg[n].ctl == relc_pkg::CTL_PROG_OFF &&
                     !prog_q[n] && prog[n]) begin
          cfg[n].ctl <= relc_pkg::CTL_PROG;
        end
        if (wr && wb_adr_i == relay_adr(n, relc_pkg::OFS_HOLD)) begin
          hold[n] <= 16'(merge({16'h0000, hold[n]}, wb_dat_i, wb_sel_i));
        end
        if (wr && wb_adr_i == relay_adr(n, relc_pkg::OFS_SCHED)) begin
          sched[n] <= relc_pkg::relc_sched_type'(merge(32'(sched[n]),
                      wb_dat_i, wb_sel_i) & 32'h837F_07FF);
        end
        if (sched_on[n]) begin
          sched_lv[n] <= 1'b1;
        end else if (sched_off[n]) begin
          sched_lv[n] <= 1'b0;
        end
        if (pulse_start[n]) begin
          pulse_cnt[n] <= hold[n];
        end else if (tick && pulse_cnt[n] != 16'h0000) begin
          pulse_cnt[n] <= pulse_cnt[n] - 16'h0001;
        end
        case (cfg[n].ctl)
          relc_pkg::CTL_ON, relc_pkg::CTL_PROG_ON: out_q[n] <= 1'b1;
          relc_pkg::CTL_OFF, relc_pkg::CTL_PROG_OFF: out_q[n] <= 1'b0;
          default: out_q[n] <= prog[n];
        endcase
      end
    end
  end

  assign buzzer_o = out_q[0];
  assign relay_o = out_q[NO-1:1];

  // Read data
  always_comb begin
    rdata = 32'h0000_0000;
    if (wb_adr_i == relc_pkg::ADR_UNIT) begin
      rdata = {27'h000_0000, pin_only_en, 2'h0, mode};
    end else if (wb_adr_i == relc_pkg::ADR_STATUS) begin
      rdata = {8'h00, inp, forced_lv, ajar_l, shunt, strike_act, 3'h0,
               out_q};
    end else if (wb_adr_i == relc_pkg::ADR_STRIKE) begin
      rdata = {16'h0000, strike_time};
    end else if (wb_adr_i == relc_pkg::ADR_AJAR) begin
      rdata = {16'h0000, ajar_time};
    end else begin
      for (int n = 0; n < NO; n++) begin
        if (wb_adr_i == relay_adr(n, relc_pkg::OFS_CFG)) begin
          rdata = 32'(cfg[n]);
        end else if (wb_adr_i == relay_adr(n, relc_pkg::OFS_HOLD)) begin
          rdata = {16'h0000, hold[n]};
        end else if (wb_adr_i == relay_adr(n, relc_pkg::OFS_SCHED)) begin
          rdata = 32'(sched[n]);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc && !ack_q) begin
      wb_dat_o <= rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  strike_load_a: assert property (rls[0] |=>
    strike_cnt[0] == $past(strike_time)) else $error("strike not loaded");
  forced_evt_a: assert property (door[0] && !door_q[0] && !strike_act[0]
    |=> forced_ev[0] ##1 (forced_lv[0] || !door[0]))
    else $error("door forced missed");
  duress_evt_a: assert property (dur_hit[0] |=> duress_ev[0] &&
    strike_act[0] == ($past(strike_time) != 16'h0000))
    else $error("duress missed");
  bad_pin_a: assert property (pin_bad[0] && wrong_cnt[0] == 3'h3 |=>
    bad_pin_ev[0] && wrong_cnt[0] == 3'h0) else $error("bad pin missed");
  shunt_on_a: assert property (rls[0] |=> shunt[0])
    else $error("shunt not set");

  for (genvar g = 0; g < NO; g++) begin : g_chk
    sequence prog_fall_s;
      prog_q[g] && !prog[g];
    endsequence
    sequence quiet_s;
      !cfg_wr[g] && !card_hit[g] && !(wr && wb_adr_i == relc_pkg::ADR_UNIT);
    endsequence
    forced_on_a: assert property (cfg[g].ctl == relc_pkg::CTL_ON |=>
      out_q[g]) else $error("forced on output low");
    forced_off_a: assert property (cfg[g].ctl == relc_pkg::CTL_OFF |=>
      !out_q[g]) else $error("forced off output high");
    prog_follow_a: assert property (cfg[g].ctl == relc_pkg::CTL_PROG |=>
      out_q[g] == $past(prog[g])) else $error("programmed mismatch");
    prog_on_end_a: assert property (
      cfg[g].ctl == relc_pkg::CTL_PROG_ON ##0 quiet_s ##0 prog_fall_s
      |=> cfg[g].ctl == relc_pkg::CTL_PROG ##1 out_q[g] == $past(prog[g]))
      else $error("programmed on did not end");
    prog_off_end_a: assert property (
      cfg[g].ctl == relc_pkg::CTL_PROG_OFF ##0 quiet_s ##0
      (!prog_q[g] && prog[g]) |=> cfg[g].ctl == relc_pkg::CTL_PROG)
      else $error("programmed off did not end");
    pulse_hold_a: assert property (pulse_start[g] && hold[g] != 16'h0000
      |=> pulse_cnt[g] == $past(hold[g]) ##0 prog[g])
      else $error("pulse not held");
    card_toggle_a: assert property (card_hit[g] && !cfg_wr[g] &&
      !(wr && wb_adr_i == relc_pkg::ADR_UNIT) |=>
      cfg[g].ctl == ($past(cfg[g].ctl) == relc_pkg::CTL_ON ?
      relc_pkg::CTL_PROG : relc_pkg::CTL_ON)) else $error("card toggle");
  end

endmodule : relc_relay_ctrl
`default_nettype wire

// *** rtl/relc_pkg.sv ***
/*
  Package for the relay output controller: register map, field layouts,
  enumerations and timing constants.
  Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave.
*/
package relc_pkg;

  localparam int unsigned N_OUT = 5;
  localparam int unsigned N_DOOR = 2;
  localparam int unsigned N_IN = 8;

  // Timing: one hold/strike/ajar tick is 100 ms
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Register byte offsets
  localparam logic [7:0] ADR_UNIT = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_STRIKE = 8'h08;
  localparam logic [7:0] ADR_AJAR = 8'h0C;
  localparam logic [7:0] ADR_RELAY_BASE = 8'h20;
  localparam logic [7:0] ADR_RELAY_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_HOLD = 8'h04;
  localparam logic [7:0] OFS_SCHED = 8'h08;

  // Unit control fields
  localparam int unsigned UNIT_MODE_LSB = 0;
  localparam int unsigned UNIT_PIN_ONLY_BIT = 4;

  // Reset values, in ticks
  localparam logic [15:0] STRIKE_RST = 16'h0032;
  localparam logic [15:0] AJAR_RST = 16'h012C;
  localparam logic [15:0] HOLD_RST = 16'h0032;

  typedef enum logic [1:0] {
    MODE_2R2D = 2'b00, MODE_2R1D = 2'b01, MODE_1R1D = 2'b11,
    MODE_LIFT = 2'b10
  } relc_mode_type;

  typedef enum logic [2:0] {
    CTL_PROG = 3'b000, CTL_PROG_OFF = 3'b001, CTL_PROG_ON = 3'b011,
    CTL_PULSE = 3'b010, CTL_OFF = 3'b110, CTL_ON = 3'b111
  } relc_ctl_type;

  typedef enum logic [3:0] {
    SRC_NONE = 4'h0, SRC_STRIKE = 4'h1, SRC_SHUNT = 4'h2,
    SRC_AJAR_L = 4'h3, SRC_AJAR_R = 4'h4, SRC_FORCED = 4'h5,
    SRC_DURESS = 4'h6, SRC_BAD_ID = 4'h7, SRC_BAD_PIN = 4'h8,
    SRC_INPUT = 4'h9, SRC_IN_FAULT = 4'hA, SRC_SCHED = 4'hB
  } relc_src_type;

  typedef enum logic [1:0] {
    HOL_ALL = 2'b00, HOL_NOT = 2'b01, HOL_ONLY = 2'b11
  } relc_hol_type;

  typedef enum logic [1:0] {
    ACT_OFF = 2'b00, ACT_ON = 2'b01, ACT_PULSE = 2'b11
  } relc_act_type;

  typedef struct packed {
    logic [14:0] pad3;
    logic door;
    logic pad2;
    logic [2:0] in_sel;
    logic [1:0] pad1;
    relc_hol_type hol;
    relc_src_type src;
    logic pad0;
    relc_ctl_type ctl;
  } relc_cfg_type;

  typedef struct packed {
    logic en;
    logic [4:0] pad2;
    relc_act_type act;
    logic pad1;
    logic [6:0] days;
    logic [4:0] pad0;
    logic [10:0] minute;
  } relc_sched_type;

  typedef struct packed {
    logic cred_ok;
    logic pin_check;
    logic [15:0] pin_entered;
    logic [15:0] pin_stored;
    logic bad_id;
    logic ajar_remote;
  } relc_rdr_ev_type;

  typedef struct packed {
    logic minute_pulse;
    logic [10:0] minute;
    logic [2:0] weekday;
    logic holiday;
  } relc_time_type;

endpackage : relc_pkg

// *** dv/relc_door_model.sv ***
/*
  Door model at the far side: strike relay and door sensor of one door.
  Assumes strike from the relay output, push and force from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module relc_door_model (
  input wire logic clk_i,
  input wire logic strike_i,
  input wire logic push_i,
  input wire logic force_i,
  output logic open_o
);
  // Opens only if released or forced; stays open while pushed
  always_ff @(posedge clk_i) begin
    open_o <= push_i & (strike_i | force_i | open_o);
  end
endmodule : relc_door_model
`default_nettype wire

// *** dv/relc_relay_ctrl_tb_top.sv ***
/*
  Self-checking bench for the relay output controller.
  Assumes a short tick parameter and a one-cycle Wishbone answer.
*/
`timescale 1ns/1ns
`default_nettype none
module relc_relay_ctrl_tb_top;
  localparam int T = 4;
  localparam int H = 3;
  logic clk_i = 0, rst_i = 1, we = 0, stb = 0, ack, buz, dop;
  logic push = 0, frc = 0, cpin = 0;
  logic [7:0] adr = 0, pins = 0, flt = 0;
  logic [31:0] wdat = 0, rdat, dat_o;
  logic [4:0] card = 0, outs;
  logic [3:0] rel;
  relc_pkg::relc_rdr_ev_type [1:0] ev = '0;
  relc_pkg::relc_time_type tm = '0;
  int fails = 0, samples_checked = 0, cyc_n = 0, n;
  logic [7:0] ad [8] = '{8'h20, 8'h20, 8'h60, 8'h60, 8'h30, 8'h30,
                         8'h30, 8'h30};
  logic [19:0] cf [8] = '{20'h7, 20'h0, 20'h7, 20'h6, 20'h2090,
                          20'h2091, 20'h2093, 20'h2090};
  logic [7:0] pn [8] = '{0, 0, 0, 0, 8'h04, 8'h04, 8'h00, 8'h00};
  logic [4:0] ex [8] = '{5'h01, 0, 5'h10, 0, 5'h02, 0, 5'h02, 0};
  assign outs = {rel, buz};
  relc_relay_ctrl #(.TICK_CYCLES(T)) relc_relay_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .door_open_i({1'b0, dop}),
    .in_pin_i(pins), .in_fault_i(flt), .rdr_ev_i(ev), .time_i(tm),
    .ctrl_card_i(card), .ctrl_card_pin_i(cpin), .buzzer_o(buz),
    .relay_o(rel));
  relc_door_model relc_door_model_i (.clk_i(clk_i), .strike_i(rel[0]),
    .push_i(push), .force_i(frc), .open_o(dop));
  initial forever #20 clk_i = ~clk_i;
  task automatic final_report;
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    adr <= a;
    wdat <= d;
    we <= w;
    stb <= 1;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rdat = dat_o;
    stb <= 0;
    @(posedge clk_i);
  endtask : wb
  // Waits for output k, then counts its high cycles
  task automatic measure(int k);
    int w;
    w = 0;
    n = 0;
    while (outs[k] !== 1'b1 && w < 10) begin
      @(posedge clk_i);
      w++;
    end
    while (outs[k] === 1'b1 && n < 999) begin
      @(posedge clk_i);
      n++;
    end
  endtask : measure
  task automatic pin(logic [15:0] e);
    ev[0].pin_stored <= 16'h1234;
    ev[0].pin_entered <= e;
    ev[0].pin_check <= 1;
    @(posedge clk_i);
    ev[0].pin_check <= 0;
  endtask : pin
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    repeat (3) @(posedge clk_i);
    check("outs", outs, 0);
    wb(0, 8'h08, 0);
    check("strike", rdat, 32'h0000_0032);
    wb(0, 8'h1C, 0);
    check("unmapped", rdat, 0);
    for (int i = 0; i < 8; i++) begin
      pins <= pn[i];
      repeat (3) @(posedge clk_i);
      wb(1, ad[i], {12'h000, cf[i]});
      repeat (6) @(posedge clk_i);
      check("outs", outs, ex[i]);
    end
    wb(1, 8'h30, 32'h0000_2091);
    pins <= 8'h04;
    repeat (6) @(posedge clk_i);
    check("prog_off_end", outs[1], 1);
    wb(1, 8'h30, 32'h0000_2093);
    pins <= 8'h00;
    repeat (6) @(posedge clk_i);
    check("prog_on_end", outs[1], 0);
    wb(1, 8'h44, H);
    wb(1, 8'h40, 32'h0000_0002);
    measure(2);
    check("pulse", n > (H - 1) * T && n <= H * T, 1);
    wb(1, 8'h40, 32'h0000_0070);
    ev[0].bad_id <= 1;
    @(posedge clk_i);
    ev[0].bad_id <= 0;
    measure(2);
    check("bad_id", n > (H - 1) * T && n <= H * T, 1);
    wb(1, 8'h40, 32'h0000_0060);
    pin(16'h1235);
    measure(2);
    check("duress", n > (H - 1) * T && n <= H * T, 1);
    wb(1, 8'h40, 32'h0000_0080);
    repeat (3) begin
      pin(16'h1111);
      repeat (8) @(posedge clk_i);
    end
    check("bad_pin3", outs[2], 0);
    pin(16'h1111);
    measure(2);
    check("bad_pin4", n > (H - 1) * T && n <= H * T, 1);
    wb(1, 8'h00, 0);
    wb(1, 8'h08, 2);
    ev[0].cred_ok <= 1;
    @(posedge clk_i);
    ev[0].cred_ok <= 0;
    repeat (4) @(posedge clk_i);
    check("strike_shunt", {outs[3], outs[1]}, 2'b11);
    measure(1);
    check("strike_len", n > 0 && n <= 2 * T, 1);
    repeat (3) @(posedge clk_i);
    check("shunt_end", outs[3], 0);
    wb(1, 8'h60, 32'h0000_0050);
    push <= 1;
    frc <= 1;
    repeat (8) @(posedge clk_i);
    check("forced", outs[4], 1);
    push <= 0;
    repeat (6) @(posedge clk_i);
    check("closed", outs[4], 0);
    card <= 5'h10;
    cpin <= 1;
    @(posedge clk_i);
    card <= 0;
    cpin <= 0;
    repeat (4) @(posedge clk_i);
    check("card_pin", outs[4], 0);
    for (int i = 1; i >= 0; i--) begin
      card <= 5'h10;
      @(posedge clk_i);
      card <= 0;
      repeat (4) @(posedge clk_i);
      check("card", outs[4], i);
    end
    wb(1, 8'h60, 32'h0000_00A0);
    flt <= 8'h10;
    repeat (5) @(posedge clk_i);
    check("fault", outs[4], 1);
    flt <= 0;
    wb(1, 8'h68, 32'hC104_0005);
    wb(0, 8'h68, 0);
    check("sched_rd", rdat, 32'h8104_0005);
    wb(1, 8'h60, 32'h0000_01B0);
    for (int j = 1; j >= 0; j--) begin
      tm <= {1'b1, 11'h005, 3'h2, j[0]};
      @(posedge clk_i);
      tm.minute_pulse <= 0;
      repeat (3) @(posedge clk_i);
      check("sched", outs[4], j == 0);
    end
    final_report();
  end
endmodule : relc_relay_ctrl_tb_top
`default_nettype wire
